// file: inc/ubtc_pkg.sv
// Package: register map, field layout, reset values and timing of the bulk-in timing block
package ubtc_pkg;

  typedef enum logic [1:0] {SPEED_SS, SPEED_HS, SPEED_FS, SPEED_LS} ubtc_speed_type;
  typedef enum logic {DET_IDLE, DET_ACTIVE} ubtc_detach_type;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFS_CONFIG_FIRST = 12'h080;
  localparam logic [11:0] OFS_DETACH       = 12'h088;
  localparam logic [11:0] OFS_STATUS       = 12'h08C;
  localparam logic [11:0] OFS_BURST        = 12'h090;
  localparam logic [11:0] OFS_DELAY        = 12'h094;
  localparam logic [11:0] OFS_NONE         = 12'hFFF;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

  // Field positions in usb_config_first
  localparam int SCALE_LSB    = 0;
  localparam int FS_CAL_LSB   = 4;
  localparam int LAT_TOL_BIT  = 8;
  localparam int HOST_U1_BIT  = 9;
  localparam int U1_INIT_BIT  = 10;
  localparam int HS_CAL_LSB   = 12;
  localparam int BURST_EN_BIT = 16;

  // ****************************************
  // Loadable image layout and fallbacks
  // ****************************************
  localparam int IMG_W         = 41;
  localparam int IMG_SUPER_LSB = 25;
  localparam int IMG_HIGH_LSB  = 9;
  localparam int IMG_U1_INIT   = 8;
  localparam int IMG_HOST_U1   = 7;
  localparam int IMG_LAT_TOL   = 6;
  localparam int IMG_HS_CAL    = 3;
  localparam int IMG_FS_CAL    = 0;

  localparam logic [15:0] SUPER_DETACH_DEF = 16'h001E;
  localparam logic [15:0] HIGH_DETACH_DEF  = 16'h000A;
  localparam logic        U1_INIT_DEF      = 1'h0;
  localparam logic        HOST_U1_DEF      = 1'h1;
  localparam logic        LAT_TOL_DEF      = 1'h0;
  localparam logic [2:0]  HS_CAL_DEF       = 3'h0;
  localparam logic [2:0]  FS_CAL_DEF       = 3'h0;
  localparam logic [IMG_W-1:0] IMG_FALLBACK = {SUPER_DETACH_DEF, HIGH_DETACH_DEF, U1_INIT_DEF,
                                               HOST_U1_DEF, LAT_TOL_DEF, HS_CAL_DEF, FS_CAL_DEF};

  localparam logic [1:0]  SCALE_RESET = 2'h0;
  localparam logic [7:0]  BURST_RESET = 8'h00;
  localparam logic [15:0] DELAY_RESET = 16'h0800;

  // ****************************************
  // Burst units and timing
  // ****************************************
  localparam logic [10:0] UNIT_SS     = 11'h400;
  localparam logic [10:0] UNIT_HS     = 11'h200;
  localparam logic [10:0] UNIT_FS     = 11'h040;
  localparam logic [18:0] BURST_FLOOR = 19'h0_0800;

  localparam int CLK_PS           = 25000;
  localparam int MS_PS            = 1_000_000_000;
  localparam int MS_CYCLES        = MS_PS / CLK_PS;
  localparam int SCALED_MS_CYCLES = 40;
  localparam int DELAY_UNIT_PS    = 16667;
  localparam int DELAY_HALF_STEP  = (2 * CLK_PS + DELAY_UNIT_PS / 2) / DELAY_UNIT_PS;

  localparam logic [15:0] TXEQ_FULL          = 16'h0100;
  localparam logic [15:0] TXEQ_SCALED        = 16'h0008;
  localparam int          POLL_SCALED_PS     = 100_000;
  localparam int          POLL_SCALED_CYCLES = (POLL_SCALED_PS + CLK_PS - 1) / CLK_PS;
  localparam int          POLL_FULL_CYCLES   = 40;
  localparam int          WARM_SCALED_PS     = 30_000_000;
  localparam int          WARM_SCALED_CYCLES = (WARM_SCALED_PS + CLK_PS - 1) / CLK_PS;
  localparam int          WARM_FULL_CYCLES   = 4000;

endpackage

// file: hw/ubtc_ms_timer.sv
// Millisecond down-counter used to hold the bus detached
`timescale 1ns/1ps
module ubtc_ms_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [15:0] ms_load,
  input  wire logic [15:0] cycles_per_ms,
  output logic             busy,
  output logic             done
);
  import ubtc_pkg::*;

  logic [15:0] div;
  logic [15:0] remain;

  wire div_wrap = (div == cycles_per_ms - 16'h0001);

  // Pulse in the last busy cycle; busy drops at the following edge
  assign done = busy && (remain == 16'h0000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy   <= 1'h0;
      div    <= 16'h0000;
      remain <= 16'h0000;
    end else if (start) begin
      busy   <= 1'h1;
      div    <= 16'h0000;
      remain <= ms_load;
    end else if (done) begin
      busy <= 1'h0;
    end else if (busy && div_wrap) begin
      div    <= 16'h0000;
      remain <= remain - 16'h0001;
    end else if (busy) begin
      div <= div + 16'h0001;
    end
  end

  AST_TIMER_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && ms_load == 16'h0000 |=> done ##1 !busy)
    else $error("Zero millisecond load did not finish in one cycle");

endmodule

// file: hw/ubtc_top.sv
// Bulk-in burst, short packet delay, detach timing and scale-down configuration block
//
// Contract
// - HS/FS/LS scale code 01 other timers, 10 suspend/resume, 11 both.
// - SS scale 01: eight TxEq sequences, 100 ns polling burst, 30 us warm reset.
// - SS scale 10: no TxEq training sequences at all.
// - Power-on values come from EEPROM, else OTP, else fallback.
// - USB or lite reset restores last loaded image or fallback.
// - Fallback: U1 initiate and latency tolerance 0, host U1 accept 1.
// - Fallback: both timeout calibration fields zero.
// - Soft reset in SuperSpeed detaches for upper detach field milliseconds; at SS scale 01 or 11 the code counts each millisecond as 40 cycles.
// - Soft reset in HS/FS detaches for lower detach field milliseconds.
// - Fallback SuperSpeed detach time is 0x1E ms.
// - Fallback HS/FS detach time is 0x0A ms.
// - Reaching the burst limit ends the burst with a zero-length packet.
// - Burst limit units: 1024 bytes SS, 512 HS, 64 FS.
// - Burst limit ignored when it converts to 2048 bytes or less.
// - Burst limit acts only while its enable bit is set.
// - Short packets and zero-length packets wait the programmed delay first.
// - Delay counts 16.667 ns steps, reset value 0800h.
// - Each FS calibration count adds 0.2 bit times.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module ubtc_top #(
  parameter int MS_CYCLES_P = ubtc_pkg::MS_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire ubtc_pkg::ubtc_speed_type link_speed,
  input  wire logic                     soft_reset_req,
  input  wire logic                     usb_reset,
  input  wire logic                     lite_reset,
  input  wire logic                     image_load,
  input  wire logic                     eeprom_present,
  input  wire logic [40:0]              eeprom_image,
  input  wire logic                     otp_present,
  input  wire logic [40:0]              otp_image,
  input  wire logic                     pkt_done,
  input  wire logic                     pkt_short,
  input  wire logic [10:0]              pkt_bytes,
  input  wire logic                     short_pending,
  output logic                          bus_detach,
  output logic                          scale_other_timers,
  output logic                          scale_suspend_resume,
  output logic      [15:0]              txeq_train_count,
  output logic                          txeq_skip,
  output logic      [11:0]              lfps_poll_burst_cycles,
  output logic      [15:0]              warm_reset_detect_cycles,
  output logic                          u1_initiate_enable,
  output logic                          host_u1_accept_enable,
  output logic                          latency_tolerance_enable,
  output logic      [2:0]               timeout_calibration,
  output logic      [3:0]               fs_timeout_extra_tenths,
  output logic                          burst_limit_active,
  output logic                          zlp_request,
  output logic                          short_send_ok
);
  import ubtc_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [1:0]       scale;
  logic             burst_en;
  logic [7:0]       burst_limit;
  logic [15:0]      delay;
  logic [IMG_W-1:0] live;
  logic [IMG_W-1:0] image;
  logic [19:0]      burst_bytes;
  logic [17:0]      delay_half;
  ubtc_detach_type  det_state;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic        wr_pend;
  logic [11:0] wr_ofs;
  logic [31:0] rd_mux;
  logic [31:0] rd_config;
  logic [31:0] rd_status;

  // Upper address bits outside the block map decode to nothing
  wire [11:0] sel_ofs   = (haddr[31:12] == 20'h0_0000) ? haddr[11:0] : OFS_NONE;
  wire        addr_take = hsel && htrans[1] && hready;
  wire        wr_take   = addr_take && hwrite && (hsize == HSIZE_WORD);
  wire        wr_config = wr_pend && (wr_ofs == OFS_CONFIG_FIRST);
  wire        wr_detach = wr_pend && (wr_ofs == OFS_DETACH);
  wire        wr_burst  = wr_pend && (wr_ofs == OFS_BURST);
  wire        wr_delay  = wr_pend && (wr_ofs == OFS_DELAY);

  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;

  assign rd_config = {15'h0000, burst_en, 1'h0, live[IMG_HS_CAL +: 3], 1'h0,
                      live[IMG_U1_INIT], live[IMG_HOST_U1], live[IMG_LAT_TOL], 1'h0,
                      live[IMG_FS_CAL +: 3], 2'h0, scale};
  assign rd_status = {8'h00, bus_detach, zlp_request, burst_limit_active, 1'h0, burst_bytes};

  assign rd_mux = (sel_ofs == OFS_CONFIG_FIRST) ? rd_config :
                  (sel_ofs == OFS_DETACH)       ? live[IMG_W-1:IMG_HIGH_LSB] :
                  (sel_ofs == OFS_STATUS)       ? rd_status :
                  (sel_ofs == OFS_BURST)        ? {24'h00_0000, burst_limit} :
                  (sel_ofs == OFS_DELAY)        ? {16'h0000, delay} :
                                                  32'h0000_0000;

  // Read data is captured in the address phase, so a read issued in the
  // data phase of a write to the same register returns the old value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'h0;
      wr_ofs  <= 12'h000;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= wr_take;
      if (addr_take) begin
        wr_ofs <= sel_ofs;
      end
      if (addr_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scale       <= SCALE_RESET;
      burst_en    <= 1'h0;
      burst_limit <= BURST_RESET;
      delay       <= DELAY_RESET;
    end else begin
      if (wr_config) begin
        scale    <= hwdata[SCALE_LSB +: 2];
        burst_en <= hwdata[BURST_EN_BIT];
      end
      if (wr_burst) begin
        burst_limit <= hwdata[7:0];
      end
      if (wr_delay) begin
        delay <= hwdata[15:0];
      end
    end
  end

  // ****************************************
  // Loadable fields and their image
  // ****************************************
  wire [IMG_W-1:0] live_det_wr = {hwdata, live[IMG_HIGH_LSB-1:0]};
  wire [IMG_W-1:0] live_cfg_wr = {live[IMG_W-1:IMG_HIGH_LSB], hwdata[U1_INIT_BIT],
                                  hwdata[HOST_U1_BIT], hwdata[LAT_TOL_BIT],
                                  hwdata[HS_CAL_LSB +: 3], hwdata[FS_CAL_LSB +: 3]};

  wire [IMG_W-1:0] load_pick = eeprom_present ? eeprom_image :
                               otp_present    ? otp_image    : IMG_FALLBACK;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      live  <= IMG_FALLBACK;
      image <= IMG_FALLBACK;
    end else if (image_load) begin
      live  <= load_pick;
      image <= load_pick;
    end else if (usb_reset || lite_reset) begin
      live <= image;
    end else if (wr_detach) begin
      live <= live_det_wr;
    end else if (wr_config) begin
      live <= live_cfg_wr;
    end
  end

  assign u1_initiate_enable       = live[IMG_U1_INIT];
  assign host_u1_accept_enable    = live[IMG_HOST_U1];
  assign latency_tolerance_enable = live[IMG_LAT_TOL];

  // ****************************************
  // Link timing selection
  // ****************************************
  wire is_ss = (link_speed == SPEED_SS);
  wire is_fs = (link_speed == SPEED_FS) || (link_speed == SPEED_LS);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scale_other_timers       <= 1'h0;
      scale_suspend_resume     <= 1'h0;
      txeq_train_count         <= TXEQ_FULL;
      txeq_skip                <= 1'h0;
      lfps_poll_burst_cycles   <= 12'(POLL_FULL_CYCLES);
      warm_reset_detect_cycles <= 16'(WARM_FULL_CYCLES);
      timeout_calibration      <= 3'h0;
      fs_timeout_extra_tenths  <= 4'h0;
    end else begin
      scale_other_timers   <= !is_ss && scale[0];
      scale_suspend_resume <= !is_ss && scale[1];
      txeq_train_count         <= (is_ss && scale[0]) ? TXEQ_SCALED : TXEQ_FULL;
      lfps_poll_burst_cycles   <= 12'((is_ss && scale[0]) ? POLL_SCALED_CYCLES
                                                           : POLL_FULL_CYCLES);
      warm_reset_detect_cycles <= 16'((is_ss && scale[0]) ? WARM_SCALED_CYCLES
                                                           : WARM_FULL_CYCLES);
      txeq_skip <= is_ss && scale[1];
      timeout_calibration <= is_fs ? live[IMG_FS_CAL +: 3] : live[IMG_HS_CAL +: 3];
      fs_timeout_extra_tenths <= {live[IMG_FS_CAL +: 3], 1'h0};
    end
  end

  // ****************************************
  // Soft reset detach
  // ****************************************
  logic timer_done;

  wire        start_detach  = soft_reset_req && (det_state == DET_IDLE);
  wire [15:0] detach_ms     = is_ss ? live[IMG_SUPER_LSB +: 16] : live[IMG_HIGH_LSB +: 16];
  // Scaled millisecond keeps simulations of a detach short
  wire [15:0] cycles_per_ms = scale[0] ? 16'(SCALED_MS_CYCLES) : 16'(MS_CYCLES_P);

  ubtc_ms_timer u_detach_timer (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .start         (start_detach),
    .ms_load       (detach_ms),
    .cycles_per_ms (cycles_per_ms),
    .busy          (),
    .done          (timer_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      det_state <= DET_IDLE;
    end else begin
      unique case (det_state)
        DET_IDLE: begin
          if (start_detach) begin
            det_state <= DET_ACTIVE;
          end
        end
        DET_ACTIVE: begin
          if (timer_done) begin
            det_state <= DET_IDLE;
          end
        end
      endcase
    end
  end

  assign bus_detach = (det_state == DET_ACTIVE);

  // ****************************************
  // Bulk-in burst limit
  // ****************************************
  function automatic logic [10:0] burst_unit(ubtc_speed_type s);
    unique case (s)
      SPEED_SS: burst_unit = UNIT_SS;
      SPEED_HS: burst_unit = UNIT_HS;
      SPEED_FS: burst_unit = UNIT_FS;
      SPEED_LS: burst_unit = UNIT_FS;
    endcase
  endfunction

  wire [18:0] limit_bytes = 19'(burst_limit) * 19'(burst_unit(link_speed));
  assign burst_limit_active = burst_en && (limit_bytes > BURST_FLOOR);

  wire limit_hit  = burst_limit_active && (burst_bytes >= {1'h0, limit_bytes});
  wire burst_ends = pkt_done && pkt_short;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst_bytes <= 20'h0_0000;
      zlp_request <= 1'h0;
    end else begin
      if (burst_ends) begin
        burst_bytes <= 20'h0_0000;
      end else if (pkt_done && !burst_bytes[19]) begin
        burst_bytes <= burst_bytes + 20'(pkt_bytes);
      end
      zlp_request <= limit_hit && !burst_ends;
    end
  end

  // ****************************************
  // Short packet delay
  // ****************************************
  // Counts in half steps: one 25 ns cycle is three halves of 16.667 ns
  wire        waiting = short_pending || zlp_request;
  wire [17:0] target  = {1'h0, delay, 1'h0};
  wire        reached = (delay_half >= target);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      delay_half <= 18'h0_0000;
    end else if (!waiting || pkt_done) begin
      delay_half <= 18'h0_0000;
    end else if (!reached) begin
      delay_half <= delay_half + 18'(DELAY_HALF_STEP);
    end
  end

  assign short_send_ok = waiting && reached;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_SCALE_HS: assert property (scale == 2'h1 && link_speed == SPEED_HS
    |=> scale_other_timers && !scale_suspend_resume)
    else $error("Scale code 01 did not pick the other-timer set");
  AST_SS_SHORT: assert property (is_ss && scale == 2'h1
    |=> txeq_train_count == 16'h0008 && lfps_poll_burst_cycles == 12'h004
        && warm_reset_detect_cycles == 16'h04B0 && !txeq_skip)
    else $error("SuperSpeed scaled values wrong");
  AST_SS_SKIP: assert property (is_ss && scale == 2'h2 |=> txeq_skip)
    else $error("TxEq skip missing for scale code 10");
  AST_LOAD_PICK: assert property (image_load && eeprom_present
    |=> live == $past(eeprom_image) && image == $past(eeprom_image))
    else $error("EEPROM image not taken first");
  AST_RELOAD: assert property ((usb_reset || lite_reset) && !image_load
    |=> live == $past(image))
    else $error("Reset did not restore the image");
  AST_FALL_FLAGS: assert property (image_load && !eeprom_present && !otp_present
    |=> !u1_initiate_enable && host_u1_accept_enable && !latency_tolerance_enable)
    else $error("Fallback enable bits wrong");
  AST_FALL_CAL: assert property (image_load && !eeprom_present && !otp_present
    |=> live[5:0] == 6'h00)
    else $error("Fallback calibration not zero");
  AST_FALL_SUPER: assert property (image_load && !eeprom_present && !otp_present
    |=> live[40:25] == 16'h001E)
    else $error("Fallback SuperSpeed detach not 0x1E");
  AST_FALL_HIGH: assert property (image_load && !eeprom_present && !otp_present
    |=> live[24:9] == 16'h000A)
    else $error("Fallback high-speed detach not 0x0A");
  AST_DETACH_GO: assert property (start_detach && is_ss
    && live[40:25] != 16'h0000 |=> bus_detach[*3])
    else $error("SuperSpeed detach not held");
  AST_DETACH_ZERO: assert property (start_detach && link_speed == SPEED_HS
    && live[24:9] == 16'h0000 |=> bus_detach ##1 !bus_detach)
    else $error("Zero ms detach did not end after one cycle");
  AST_ZLP_CAUSE: assert property ($rose(zlp_request)
    |-> $past(burst_limit_active && burst_bytes >= {1'h0, limit_bytes}))
    else $error("Zero-length request without reaching the limit");
  AST_UNIT_SS: assert property (burst_en && is_ss && burst_limit == 8'h03
    |-> limit_bytes == 19'h0_0C00 && burst_limit_active)
    else $error("SuperSpeed unit not 1024 bytes");
  AST_FLOOR: assert property (burst_limit == 8'h04 && link_speed == SPEED_HS
    |-> !burst_limit_active)
    else $error("Limit of 2048 bytes not ignored");
  AST_ENABLE: assert property (!burst_en [*2] |-> !zlp_request)
    else $error("Burst limit acted while disabled");
  AST_DELAY_WAIT: assert property ($rose(waiting) && delay != 16'h0000
    |-> !short_send_ok)
    else $error("Short packet released without delay");
  AST_DELAY_STEP: assert property ($rose(waiting) && delay == 16'h0004 && !pkt_done
    ##1 (waiting && !pkt_done) [*3] |-> short_send_ok)
    else $error("Delay of four steps not over after three cycles");
  AST_FS_CAL: assert property (1'h1
    |=> fs_timeout_extra_tenths == {$past(live[2:0]), 1'h0})
    else $error("Full-speed extra timeout wrong");
  AST_RESTART: assert property (burst_ends |=> burst_bytes == 20'h0_0000)
    else $error("Burst count not restarted");

  COV_DETACH: cover property (start_detach ##1 bus_detach);
  COV_ZLP:    cover property ($rose(zlp_request) ##[1:50] short_send_ok);
  COV_SHORT:  cover property (short_pending && !zlp_request ##1 short_send_ok);
  COV_OTP:    cover property (image_load && !eeprom_present && otp_present);

endmodule

// file: dv/ubtc_host_model.sv
// Behavioural bulk-in packet source standing in for the far side
`timescale 1ns/1ps
module ubtc_host_model (
  input  wire logic        clk_sys,
  output logic             pkt_done,
  output logic             pkt_short,
  output logic [10:0]      pkt_bytes
);
  initial begin
    pkt_done = 1'b0;
    pkt_short = 1'b0;
    pkt_bytes = 11'h7FF;
  end
  // One packet per call; byte count turns to junk once the strobe drops
  task send(input logic [10:0] n, input logic s);
    pkt_done <= 1'b1;
    pkt_short <= s;
    pkt_bytes <= n;
    @(posedge clk_sys);
    pkt_done <= 1'b0;
    pkt_bytes <= ~n;
  endtask
endmodule

// file: dv/tb_top.sv
// Register and bulk-in timing testbench for the configuration block
`timescale 1ns/1ps
module tb_top;
  import ubtc_pkg::*;
  logic clk_sys = 0, reset_n = 0, hsel = 0, hwrite = 0, det;
  logic [3:0] pv = 4'h0;
  logic eeprom_present = 0;
  logic otp_present = 0, short_pending = 0, pkt_done, pkt_short, hrdy;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [40:0] eeprom_image = 41'h0, otp_image = 41'h0;
  logic [10:0] pkt_bytes;
  ubtc_speed_type link_speed = SPEED_HS;
  logic zlp, ok, act, skip, so, ss;
  logic [15:0] txeq, warm;
  logic [11:0] poll;
  logic [2:0] flg, tcal;
  logic [3:0] tenths;
  int bad_count = 0, total_checks = 0, cyc = 0, n, i;
  ubtc_top #(.MS_CYCLES_P(10)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
    .hready(hrdy), .hrdata(rd), .hreadyout(hrdy), .hresp(), .link_speed(link_speed),
    .soft_reset_req(pv[0]), .usb_reset(pv[1]), .lite_reset(pv[2]),
    .image_load(pv[3]), .eeprom_present(eeprom_present), .eeprom_image(eeprom_image),
    .otp_present(otp_present), .otp_image(otp_image), .pkt_done(pkt_done),
    .pkt_short(pkt_short), .pkt_bytes(pkt_bytes), .short_pending(short_pending),
    .bus_detach(det), .scale_other_timers(so), .scale_suspend_resume(ss),
    .txeq_train_count(txeq), .txeq_skip(skip), .lfps_poll_burst_cycles(poll),
    .warm_reset_detect_cycles(warm), .u1_initiate_enable(flg[2]),
    .host_u1_accept_enable(flg[1]), .latency_tolerance_enable(flg[0]),
    .timeout_calibration(tcal), .fs_timeout_extra_tenths(tenths),
    .burst_limit_active(act), .zlp_request(zlp), .short_send_ok(ok));
  ubtc_host_model host (.clk_sys(clk_sys), .pkt_done(pkt_done), .pkt_short(pkt_short),
    .pkt_bytes(pkt_bytes));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Address phase held until hready, then data phase held until hready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hrdy !== 1'b1);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // One bit per strobe: soft reset, USB reset, lite reset, image load
  task pulse(input logic [3:0] m);
    pv <= m;
    @(posedge clk_sys);
    pv <= 4'h0;
    repeat (2) @(posedge clk_sys);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(OFS_CONFIG_FIRST, 32'h0000_0200);
    rdc(OFS_DETACH, 32'h001E_000A);
    rdc(OFS_BURST, 32'h0000_0000);
    rdc(OFS_DELAY, 32'h0000_0800);
    rdc(OFS_NONE & 12'hFFC, 32'h0000_0000);
    eeprom_present <= 1'b1;
    eeprom_image <= {16'h0003, 16'h0004, 1'b1, 1'b0, 1'b1, 3'h5, 3'h2};
    otp_present <= 1'b1;
    pulse(4'h8);
    rdc(OFS_CONFIG_FIRST, 32'h0000_5520);
    chk({flg, tcal, tenths}, {3'b101, 3'h5, 4'h4});
    xfer(1'b1, OFS_DETACH, 32'h0000_0001);
    pulse(4'h2);
    rdc(OFS_DETACH, 32'h0003_0004);
    eeprom_present <= 1'b0;
    otp_present <= 1'b0;
    pulse(4'h8);
    xfer(1'b1, OFS_DETACH, 32'h0000_0001);
    pulse(4'h4);
    rdc(OFS_DETACH, 32'h001E_000A);
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, OFS_CONFIG_FIRST, i);
      repeat (2) @(posedge clk_sys);
      chk({so, ss}, {i[0], i[1]});
    end
    link_speed <= SPEED_SS;
    xfer(1'b1, OFS_CONFIG_FIRST, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk({skip, txeq}, {1'b0, TXEQ_SCALED});
    chk({poll, warm}, {12'h004, 16'h04B0});
    xfer(1'b1, OFS_CONFIG_FIRST, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk(skip, 1'b1);
    link_speed <= SPEED_HS;
    // Scale back to real timing before the traffic tests
    xfer(1'b1, OFS_CONFIG_FIRST, 32'h0001_0000);
    xfer(1'b1, OFS_BURST, 32'h0000_0004);
    rdc(OFS_BURST, 32'h0000_0004);
    chk(act, 1'b0);
    xfer(1'b1, OFS_BURST, 32'h0000_0005);
    xfer(1'b1, OFS_DELAY, 32'h0000_001E);
    chk(act, 1'b1);
    for (i = 0; i < 5; i++) begin
      host.send(11'h200, 1'b0);
      @(posedge clk_sys);
      if (i == 3) chk(zlp, 1'b0);
    end
    repeat (2) @(posedge clk_sys);
    chk({zlp, ok}, 2'b10);
    repeat (25) @(posedge clk_sys);
    chk(ok, 1'b1);
    host.send(11'h000, 1'b1);
    repeat (2) @(posedge clk_sys);
    chk(zlp, 1'b0);
    xfer(1'b1, OFS_CONFIG_FIRST, 32'h0000_0000);
    // Enable lands at the data phase edge; look once it has settled
    @(posedge clk_sys);
    chk(act, 1'b0);
    xfer(1'b1, OFS_DETACH, 32'h0001_0002);
    // High speed detaches 2 ms, then SuperSpeed 1 ms, at 10 cycles per ms
    for (i = 0; i < 2; i++) begin
      link_speed <= i ? SPEED_SS : SPEED_HS;
      pulse(4'h1);
      n = 2;
      repeat (60) begin
        @(negedge clk_sys);
        if (det === 1'b1) n++;
      end
      chk(n, i ? 11 : 21);
    end
    report_and_stop;
  end
endmodule
